// >>> hdl/crtci_fifo.sv
`timescale 1ns/1ps
module crtci_fifo
    import crtci_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             push;
    logic             pop;

    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // ready is a register so the top can pass it straight out
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_q <= '0;
            inReady <= 1'b1;
        end else begin
            count_q <= count_d;
            inReady <= (count_d < (PW+1)'(DEPTH));
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

endmodule

// >>> hdl/crtci_pkg.sv
package crtci_pkg;

    // ---------------------------------------------------------------
    // control codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CODE_HOME      = 8'h08;
    localparam logic [7:0] CODE_ERASE     = 8'h0c;
    localparam logic [7:0] CODE_CR        = 8'h0d;
    localparam logic [7:0] CODE_DH_ON     = 8'h0e;
    localparam logic [7:0] CODE_BLINK_OFF = 8'h0f;
    localparam logic [7:0] CODE_COLOUR_LO = 8'h10;
    localparam logic [7:0] CODE_COLOUR_HI = 8'h17;
    localparam logic [7:0] CODE_SEND      = 8'h18;
    localparam logic [7:0] CODE_RIGHT     = 8'h19;
    localparam logic [7:0] CODE_LEFT      = 8'h1a;
    localparam logic [7:0] CODE_ESC       = 8'h1b;
    localparam logic [7:0] CODE_UP        = 8'h1c;
    localparam logic [7:0] CODE_FG_TARGET = 8'h1d;
    localparam logic [7:0] CODE_BG_TARGET = 8'h1e;
    localparam logic [7:0] CODE_BLINK_ON  = 8'h1f;
    localparam logic [7:0] PRINT_MIN      = 8'h20;
    localparam logic [7:0] SHIFT_LO       = 8'h60;
    localparam logic [7:0] SHIFT_HI       = 8'h7f;
    localparam logic [7:0] SHIFT_MASK     = 8'h1f;
    localparam logic [7:0] CHAR_LF        = 8'h0a;
    localparam logic [7:0] CHAR_CR        = 8'h0d;
    localparam logic [7:0] STOP_CHAR      = 8'hff;
    localparam logic [7:0] STOP_ATTR      = 8'h00;
    localparam logic [7:0] BLANK_CHAR     = 8'h20;
    localparam logic [7:0] BLANK_ATTR     = 8'h00;

    // ---------------------------------------------------------------
    // status word layout
    // ---------------------------------------------------------------
    localparam int         ST_PLOT_BIT  = 7;
    localparam int         ST_BLINK_BIT = 6;
    localparam int         ST_BG_LSB    = 3;
    localparam int         ST_FG_LSB    = 0;
    localparam logic [7:0] STATUS_RESET = 8'h07;

    localparam int ROW_W_DEF  = 5;
    localparam int COL_W_DEF  = 6;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ESC, ST_XREAD, ST_XCHAR, ST_XLF, ST_XCR
    } crtci_state_e;

endpackage

// >>> hdl/crtci_top.sv
`timescale 1ns/1ps
module crtci_top
    import crtci_pkg::*;
#(
    parameter int ROW_W = ROW_W_DEF,
    parameter int COL_W = COL_W_DEF
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             codeValid,
    output logic                  codeReady,
    input  wire logic [7:0]       codeData,
    output logic                  txValid,
    input  wire logic             txReady,
    output logic      [7:0]       txData,
    output logic                  escValid,
    output logic      [7:0]       escCode,
    output logic      [7:0]       statusWord,
    output logic                  colourTarget,
    output logic      [ROW_W-1:0] cursorRow,
    output logic      [COL_W-1:0] cursorCol
);
    localparam int ADDR_W = ROW_W + COL_W;

    // ---------------------------------------------------------------
    // input buffer
    // ---------------------------------------------------------------
    logic             fifoValid;
    logic             fifoTake;
    logic [7:0]       code;
    crtci_state_e     state_q;
    logic             take;
    logic             cmdTake;

    // stall while sending the screen so the host sees back-pressure
    assign fifoTake = (state_q == ST_IDLE) || (state_q == ST_ESC);
    assign take     = fifoValid && fifoTake;
    assign cmdTake  = take && (state_q == ST_IDLE);

    crtci_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (codeValid),
        .inReady  (codeReady),
        .inData   (codeData),
        .outValid (fifoValid),
        .outReady (fifoTake),
        .outData  (code)
    );

    // ---------------------------------------------------------------
    // display memory
    // ---------------------------------------------------------------
    logic [ADDR_W-1:0] xmAddr_q;
    logic [ADDR_W-1:0] cursorAddr;
    logic [ADDR_W-1:0] readAddr;
    logic [7:0]        readChar;
    logic [7:0]        readAttr;
    logic              isPrint;
    logic              writeEn;
    logic [7:0]        storeChar;
    logic              clearAll;

    assign cursorAddr = {cursorRow, cursorCol};
    assign readAddr   = (state_q == ST_IDLE) ? cursorAddr : xmAddr_q;
    assign isPrint    = (code >= PRINT_MIN);
    assign writeEn    = cmdTake && isPrint;
    assign clearAll   = cmdTake && (code == CODE_ERASE);

    always_comb begin
        storeChar = code;
        if (colourTarget && (code >= SHIFT_LO) && (code <= SHIFT_HI)) begin
            storeChar = code & SHIFT_MASK;
        end
        if (statusWord[ST_PLOT_BIT]) begin
            // pixel bits merge with what is already shown
            storeChar = colourTarget ? (readChar ^ code) : (readChar | code);
        end
    end

    crtci_vram #(
        .ADDR_W (ADDR_W)
    ) u_vram (
        .core_clk  (core_clk),
        .rst       (rst),
        .clearAll  (clearAll),
        .writeEn   (writeEn),
        .writeAddr (cursorAddr),
        .writeChar (storeChar),
        .writeAttr (statusWord),
        .readAddr  (readAddr),
        .readChar  (readChar),
        .readAttr  (readAttr)
    );

    // ---------------------------------------------------------------
    // cursor
    // ---------------------------------------------------------------
    logic lastCol;
    assign lastCol = (cursorCol == {COL_W{1'b1}});

    // right wraps onto the next row; left and up stop at the edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cursorRow <= '0;
            cursorCol <= '0;
        end else if (cmdTake) begin
            case (code)
                CODE_ERASE, CODE_HOME: begin
                    cursorRow <= '0;
                    cursorCol <= '0;
                end
                CODE_CR: begin
                    cursorCol <= '0;
                end
                CODE_LEFT: begin
                    if (cursorCol != '0) begin
                        cursorCol <= cursorCol - 1'b1;
                    end
                end
                CODE_UP: begin
                    if (cursorRow != '0) begin
                        cursorRow <= cursorRow - 1'b1;
                    end
                end
                default: begin
                    if (isPrint || (code == CODE_RIGHT)) begin
                        cursorCol <= cursorCol + 1'b1;
                        if (lastCol) begin
                            cursorRow <= cursorRow + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // status word and colour target
    // ---------------------------------------------------------------
    logic [2:0] colourIdx;
    logic       isColour;

    assign colourIdx = 3'(code - CODE_COLOUR_LO);
    assign isColour  = (code >= CODE_COLOUR_LO) && (code <= CODE_COLOUR_HI);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            statusWord <= STATUS_RESET;
        end else if (cmdTake) begin
            if (code == CODE_DH_ON) begin
                statusWord[ST_PLOT_BIT] <= 1'b1;
            end else if (code == CODE_BLINK_OFF) begin
                statusWord[ST_PLOT_BIT]  <= 1'b0;
                statusWord[ST_BLINK_BIT] <= 1'b0;
            end else if (code == CODE_BLINK_ON) begin
                statusWord[ST_BLINK_BIT] <= 1'b1;
            end else if (isColour && colourTarget) begin
                statusWord[ST_BG_LSB +: 3] <= colourIdx;
            end else if (isColour) begin
                statusWord[ST_FG_LSB +: 3] <= colourIdx;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            colourTarget <= 1'b0;
        end else if (cmdTake && (code == CODE_FG_TARGET)) begin
            colourTarget <= 1'b0;
        end else if (cmdTake && (code == CODE_BG_TARGET)) begin
            colourTarget <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // escape hand-off
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            escValid <= 1'b0;
            escCode  <= 8'h00;
        end else begin
            escValid <= take && (state_q == ST_ESC);
            if (take && (state_q == ST_ESC)) begin
                escCode <= code;
            end
        end
    end

    // ---------------------------------------------------------------
    // control and screen send
    // ---------------------------------------------------------------
    logic xmRowEnd;
    assign xmRowEnd = (xmAddr_q[COL_W-1:0] == {COL_W{1'b1}});

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            xmAddr_q <= '0;
            txValid  <= 1'b0;
            txData   <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmdTake && (code == CODE_ESC)) begin
                        state_q <= ST_ESC;
                    end else if (cmdTake && (code == CODE_SEND)) begin
                        xmAddr_q <= cursorAddr;
                        state_q  <= ST_XREAD;
                    end
                end
                ST_ESC: begin
                    if (take) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_XREAD: begin
                    if ((readChar == STOP_CHAR) && (readAttr == STOP_ATTR)) begin
                        state_q <= ST_IDLE;
                    end else begin
                        txData  <= readChar;
                        txValid <= 1'b1;
                        state_q <= ST_XCHAR;
                    end
                end
                ST_XCHAR: begin
                    if (txReady && xmRowEnd) begin
                        txData  <= CHAR_LF;
                        state_q <= ST_XLF;
                    end else if (txReady) begin
                        txValid  <= 1'b0;
                        xmAddr_q <= xmAddr_q + 1'b1;
                        state_q  <= ST_XREAD;
                    end
                end
                ST_XLF: begin
                    if (txReady) begin
                        txData  <= CHAR_CR;
                        state_q <= ST_XCR;
                    end
                end
                ST_XCR: begin
                    if (txReady) begin
                        txValid <= 1'b0;
                        if (xmAddr_q == {ADDR_W{1'b1}}) begin
                            state_q <= ST_IDLE;
                        end else begin
                            xmAddr_q <= xmAddr_q + 1'b1;
                            state_q  <= ST_XREAD;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_erase_home: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_ERASE) |=> (cursorRow == '0) && (cursorCol == '0))
        else $error("erase did not home cursor");
    chk_cr_column: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_CR) |=> (cursorCol == '0) && $stable(cursorRow))
        else $error("return moved wrong");
    chk_dh_set: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_DH_ON) |=> statusWord[ST_PLOT_BIT])
        else $error("double height not set");
    chk_blink_dh_off: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_BLINK_OFF)
            |=> !statusWord[ST_PLOT_BIT] && !statusWord[ST_BLINK_BIT])
        else $error("blink or double height left on");
    chk_colour_fg: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && isColour && !colourTarget
            |=> statusWord[2:0] == 3'($past(code) - CODE_COLOUR_LO)
                && $stable(statusWord[5:3]))
        else $error("foreground colour wrong");
    chk_colour_bg: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && isColour && colourTarget
            |=> statusWord[5:3] == 3'($past(code) - CODE_COLOUR_LO)
                && $stable(statusWord[2:0]))
        else $error("background colour wrong");
    chk_send_busy: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_SEND)
            |=> (state_q == ST_XREAD) ##1 (txValid || (state_q == ST_IDLE)))
        else $error("send did not start");

    chk_row_end_lf: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_q == ST_XCHAR) && txReady && xmRowEnd
            |=> txValid && (txData == CHAR_LF) ##[1:1000] txValid && (txData == CHAR_CR))
        else $error("row end not followed by line feed and return");
    chk_right_step: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_RIGHT) && !lastCol
            |=> cursorCol == COL_W'($past(cursorCol) + 1'b1))
        else $error("cursor right wrong");
    chk_left_step: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_LEFT) && (cursorCol != '0)
            |=> cursorCol == COL_W'($past(cursorCol) - 1'b1))
        else $error("cursor left wrong");
    chk_esc_pass: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_q == ST_ESC) && take |=> escValid && (escCode == $past(code)))
        else $error("escape code not handed on");
    chk_up_step: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_UP) && (cursorRow != '0)
            |=> cursorRow == ROW_W'($past(cursorRow) - 1'b1))
        else $error("cursor up wrong");
    chk_target_flag: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_FG_TARGET) |=> !colourTarget)
        else $error("target flag not cleared");
    chk_shift_fold: assert property (
        @(posedge core_clk) disable iff (rst)
        writeEn && colourTarget && !statusWord[ST_PLOT_BIT] && (code >= SHIFT_LO)
            && (code <= SHIFT_HI) |-> storeChar < PRINT_MIN)
        else $error("shifted code not folded");
    chk_blink_on: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_BLINK_ON) |=> statusWord[ST_BLINK_BIT])
        else $error("blink not set");

    chk_home_pos: assert property (
        @(posedge core_clk) disable iff (rst)
        cmdTake && (code == CODE_HOME) |=> (cursorRow == '0) && (cursorCol == '0))
        else $error("home wrong");

endmodule

// >>> hdl/crtci_vram.sv
`timescale 1ns/1ps
module crtci_vram
    import crtci_pkg::*;
#(
    parameter int ADDR_W = ROW_W_DEF + COL_W_DEF
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clearAll,
    input  wire logic              writeEn,
    input  wire logic [ADDR_W-1:0] writeAddr,
    input  wire logic [7:0]        writeChar,
    input  wire logic [7:0]        writeAttr,
    input  wire logic [ADDR_W-1:0] readAddr,
    output logic      [7:0]        readChar,
    output logic      [7:0]        readAttr
);
    localparam int DEPTH = 2 ** ADDR_W;

    logic [7:0] charMem [DEPTH];
    logic [7:0] attrMem [DEPTH];

    assign readChar = charMem[readAddr];
    assign readAttr = attrMem[readAddr];

    // every cell clears in one cycle, so a page erase never stalls the stream
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        always_ff @(posedge core_clk) begin
            if (rst || clearAll) begin
                charMem[i] <= BLANK_CHAR;
                attrMem[i] <= BLANK_ATTR;
            end else if (writeEn && (writeAddr == ADDR_W'(i))) begin
                charMem[i] <= writeChar;
                attrMem[i] <= writeAttr;
            end
        end
    end

endmodule

// >>> testbench/crt_control_code_interpreter_tb_top.sv
`timescale 1ns/1ps
module crt_control_code_interpreter_tb_top;
    import crtci_pkg::*;
    logic       core_clk, codeValid, codeReady, txValid, txReady, escValid, colourTarget;
    logic       rst = 1'b1;
    logic [7:0] codeData, txData, escCode, statusWord;
    logic [4:0] cursorRow;
    logic [5:0] cursorCol;
    logic [7:0] txQ[$], escQ[$];
    int         n_errors = 0;
    int         checked  = 0;
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    crtci_top u_dut (
        .core_clk(core_clk), .rst(rst), .codeValid(codeValid), .codeReady(codeReady),
        .codeData(codeData), .txValid(txValid), .txReady(txReady), .txData(txData),
        .escValid(escValid), .escCode(escCode), .statusWord(statusWord),
        .colourTarget(colourTarget), .cursorRow(cursorRow), .cursorCol(cursorCol));
    crtci_host_model u_host (.core_clk(core_clk), .codeReady(codeReady),
        .codeValid(codeValid), .codeData(codeData), .txReady(txReady));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpPos(input logic [4:0] r, input logic [5:0] c);
        cmp8({3'h0, cursorRow}, {3'h0, r});
        cmp8({2'h0, cursorCol}, {2'h0, c});
    endtask
    task automatic put(input logic [7:0] c, input int n = 1);
        repeat (n) u_host.sendCode(c);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic drain;
        for (int i = 0; i < 20000 && txQ.size() > 0; i++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        cmp8(8'(txQ.size()), 8'h00);
        cmp8({7'h0, txValid}, 8'h00);
    endtask
    task automatic give_verdict;
        $display("checked %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (txValid === 1'b1 && txReady === 1'b1)
            cmp8(txData, txQ.size() ? txQ.pop_front() : 8'hxx);
        if (escValid === 1'b1) cmp8(escCode, escQ.size() ? escQ.pop_front() : 8'hxx);
    end
    initial begin
        #(60000 * 50);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict;
    end
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        cmp8(statusWord, STATUS_RESET);
        cmpPos(5'd0, 6'd0);
        for (int t = 0; t < 2; t++) begin
            put(t ? CODE_BG_TARGET : CODE_FG_TARGET);
            cmp8({7'h0, colourTarget}, 8'(t));
            for (int i = 0; i < 8; i++) begin
                put(CODE_COLOUR_LO + 8'(i));
                cmp8(8'(statusWord >> (t ? ST_BG_LSB : ST_FG_LSB)) & 8'h07, 8'(i));
            end
        end
        put(CODE_DH_ON);
        cmp8(statusWord, 8'hbf);
        put(CODE_BLINK_ON);
        cmp8(statusWord, 8'hff);
        put(CODE_BLINK_OFF);
        cmp8(statusWord, 8'h3f);
        escQ.push_back(8'h05);
        put(CODE_ESC);
        put(8'h05);
        cmp8(statusWord, 8'h3f);
        $display("status test done");
        put(CODE_RIGHT, 66);
        cmpPos(5'd1, 6'd2);
        put(CODE_LEFT);
        cmpPos(5'd1, 6'd1);
        put(CODE_CR);
        cmpPos(5'd1, 6'd0);
        put(CODE_UP);
        cmpPos(5'd0, 6'd0);
        put(CODE_RIGHT);
        put(CODE_ERASE);
        cmpPos(5'd0, 6'd0);
        $display("cursor test done");
        put(CODE_RIGHT, 62);
        for (int i = 62; i < 2048; i++) begin
            txQ.push_back(BLANK_CHAR);
            if (i % 64 == 63) txQ.push_back(CHAR_LF);
            if (i % 64 == 63) txQ.push_back(CHAR_CR);
        end
        put(CODE_SEND);
        put(8'h00, 4);
        cmp8({7'h0, codeReady}, 8'h00);
        drain;
        $display("page send test done");
        put(CODE_ERASE);
        put(CODE_FG_TARGET);
        put(8'h62);
        put(CODE_BG_TARGET);
        put(8'h61);
        put(CODE_COLOUR_LO);
        put(CODE_FG_TARGET);
        put(CODE_COLOUR_LO);
        cmp8(statusWord, 8'h00);
        put(STOP_CHAR);
        put(8'h41);
        put(CODE_HOME);
        cmpPos(5'd0, 6'd0);
        txQ = '{8'h62, 8'h01};
        put(CODE_SEND);
        drain;
        $display("stop pair test done");
        put(CODE_DH_ON);
        cmp8(statusWord, 8'h80);
        put(8'h45);
        put(CODE_BG_TARGET);
        put(8'h41);
        put(CODE_HOME);
        txQ = '{8'h67, 8'h40};
        put(CODE_SEND);
        drain;
        $display("plot merge test done");
        give_verdict;
    end
endmodule

// >>> testbench/crtci_host_model.sv
`timescale 1ns/1ps
module crtci_host_model (
    input  wire logic       core_clk,
    input  wire logic       codeReady,
    output logic            codeValid,
    output logic      [7:0] codeData,
    output logic            txReady
);
    logic [31:0] rngQ = 32'h4166;
    initial begin
        codeValid = 1'b0;
        codeData  = 8'h00;
        txReady   = 1'b0;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // receiver stalls at random so held bytes get exercised
    always @(negedge core_clk) begin
        rngQ    <= xorshift(rngQ);
        txReady <= rngQ[0] | rngQ[1];
    end
    // idle line shows the inverse so a stale value is never read as fresh
    task automatic sendCode(input logic [7:0] c);
        @(negedge core_clk);
        codeValid = 1'b1;
        codeData  = c;
        while (codeReady !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        codeValid = 1'b0;
        codeData  = ~c;
    endtask
endmodule
